// ==== rtl/mum_pkg.sv ====
// Constants for the memory unit test, mode and cycle counter registers.
// Assumes a single 100 MHz core clock; shared by all mum_ modules.
package mum_pkg;

    // ----------------------------------------------------------------
    // Register selects of the privileged register port
    // ----------------------------------------------------------------
    localparam logic [2:0] SEL_MODE  = 3'h0;
    localparam logic [2:0] SEL_FLUSH = 3'h1;
    localparam logic [2:0] SEL_ALT   = 3'h2;
    localparam logic [2:0] SEL_COUNT = 3'h3;
    localparam logic [2:0] SEL_CTL   = 3'h4;

    // ----------------------------------------------------------------
    // Miss-file mode control fields
    // ----------------------------------------------------------------
    localparam int unsigned BIT_RD_NOMERGE = 0;
    localparam int unsigned BIT_WB_FLUSH   = 1;
    localparam int unsigned BIT_WR_NOMERGE = 2;
    localparam int unsigned BIT_IO_BLOCK   = 3;
    localparam int unsigned BIT_TMR_DIS    = 4;
    localparam int unsigned BIT_ARB_DIS    = 5;
    localparam int unsigned BIT_RD_PEND    = 6;
    localparam int unsigned BIT_WR_PEND    = 7;
    localparam int unsigned MODE_CTRL_W    = 6;
    localparam logic [5:0]  MODE_RESET     = 6'h00;
    localparam int unsigned IO_ADDR_BIT    = 39;

    // ----------------------------------------------------------------
    // Alternate mode, cycle counter and write buffer timer fields
    // ----------------------------------------------------------------
    localparam int unsigned ALT_LSB     = 0;
    localparam int unsigned CTL_ENA_BIT = 32;
    localparam int unsigned CTL_LO_LSB  = 4;
    localparam int unsigned ENA_DELAY   = 3;
    localparam int unsigned WB_TIMER_CYCLES = 64;

    // Privilege modes held by the alternate mode register.
    typedef enum logic [1:0] {
        MUM_KERNEL,
        MUM_EXECUTIVE,
        MUM_SUPERVISOR,
        MUM_USER
    } mum_priv_t;

endpackage : mum_pkg

// ==== rtl/mum_cycle_counter.sv ====
// Cycle counter: low 32-bit count plus upper 32-bit software offset.
// Assumes synchronous write strobes from the privileged register port.
`timescale 1ns/1ps
`default_nettype none
module mum_cycle_counter #(
    parameter int unsigned DELAY = mum_pkg::ENA_DELAY
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        hi_wr_i,
    input  wire logic        ctl_wr_i,
    input  wire logic [63:0] wdata_i,
    output logic      [63:0] count_o,
    output logic             enabled_o
);
    logic [31:0]      hi_ff;
    logic [31:0]      lo_ff;
    logic [DELAY-1:0] ena_pipe_ff;

    // ----------------------------------------------------------------
    // Enable latency pipeline
    // ----------------------------------------------------------------
    // The enable bit ripples through DELAY stages before counting starts.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ena_pipe_ff <= '0;
        end else begin
            ena_pipe_ff[0] <= ctl_wr_i ? wdata_i[mum_pkg::CTL_ENA_BIT] : ena_pipe_ff[0];
            for (int i = 1; i < DELAY; i++) begin
                ena_pipe_ff[i] <= ena_pipe_ff[i-1];
            end
        end
    end

    // ----------------------------------------------------------------
    // Count halves
    // ----------------------------------------------------------------
    // Control writes load the low half with its bottom nibble cleared.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lo_ff <= 32'h0000_0000;
        end else if (ctl_wr_i) begin
            lo_ff <= {wdata_i[31:mum_pkg::CTL_LO_LSB], 4'h0};
        end else if (ena_pipe_ff[DELAY-1]) begin
            lo_ff <= lo_ff + 32'h0000_0001;
        end
    end

    // Counter writes touch only the offset half.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_ff <= 32'h0000_0000;
        end else if (hi_wr_i) begin
            hi_ff <= wdata_i[63:32];
        end
    end

    assign count_o   = {hi_ff, lo_ff};
    assign enabled_o = ena_pipe_ff[DELAY-1];

    a_enable_latency: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (ctl_wr_i && wdata_i[32] && ena_pipe_ff == '0) ##1 (!ctl_wr_i)[*3] |=> lo_ff == $past(lo_ff, 3) + 32'h0000_0001)
        else $error("counter did not start three cycles after enable");
    a_no_early_count: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (ctl_wr_i && ena_pipe_ff == '0) ##1 (!ctl_wr_i)[*2] |-> lo_ff == $past(lo_ff))
        else $error("counter moved before enable latency");
    a_ctl_load_low: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ctl_wr_i |=> lo_ff == {$past(wdata_i[31:4]), 4'h0} && hi_ff == $past(hi_wr_i ? wdata_i[63:32] : hi_ff))
        else $error("control write loaded wrong count bits");
    a_hi_write_only: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        hi_wr_i && !ctl_wr_i && !enabled_o |=> hi_ff == $past(wdata_i[63:32]) && lo_ff == $past(lo_ff))
        else $error("counter write changed low half");
endmodule : mum_cycle_counter
`default_nettype wire

// ==== rtl/mum_wb_arbiter.sv ====
// Write buffer low-priority request timer.
// Assumes write buffer status strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module mum_wb_arbiter #(
    parameter int unsigned TIMER_CYCLES = mum_pkg::WB_TIMER_CYCLES
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic timer_disable_i,
    input  wire logic wb_valid_i,
    input  wire logic wb_second_i,
    input  wire logic load_locked_i,
    input  wire logic wb_grant_i,
    output logic      wb_low_req_o
);
    localparam int unsigned TW = $clog2(TIMER_CYCLES);
    localparam logic [TW-1:0] TMAX = TW'(TIMER_CYCLES - 1);

    logic [TW-1:0] timer_ff;
    logic          req_ff;
    logic          trigger;

    // ----------------------------------------------------------------
    // Age timer and request
    // ----------------------------------------------------------------
    // The timer runs only while an entry waits and it is not disabled.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_ff <= '0;
        end else if (!wb_valid_i || timer_disable_i || req_ff) begin
            timer_ff <= '0;
        end else begin
            timer_ff <= timer_ff + TW'(1);
        end
    end

    // Timer expiry, or with the timer off a locked load or second entry.
    assign trigger = timer_disable_i ? (load_locked_i || wb_second_i)
                                     : (timer_ff == TMAX);

    // The oldest entry keeps asking until it is served or drained.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_ff <= 1'b0;
        end else if (!wb_valid_i || wb_grant_i) begin
            req_ff <= 1'b0;
        end else if (trigger) begin
            req_ff <= 1'b1;
        end
    end

    assign wb_low_req_o = req_ff;

    a_timer_off_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        timer_disable_i && !load_locked_i && !wb_second_i && !req_ff |=> !req_ff)
        else $error("write buffer asked without cause while timer off");
    a_timer_off_trig: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        timer_disable_i && wb_valid_i && !wb_grant_i && (load_locked_i || wb_second_i) |=> req_ff)
        else $error("locked load or second entry did not raise request");
endmodule : mum_wb_arbiter
`default_nettype wire

// ==== rtl/mum_test_cycle_regs.sv ====
// Memory unit test mode, cache flush, alternate mode and cycle counter registers.
// Assumes the core drives the privileged register port and miss-file status
// synchronously on clock_i; only resetn_i arrives from outside the domain.
`timescale 1ns/1ps
`default_nettype none
module mum_test_cycle_regs (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        timeout_reset_i,
    // Privileged register port.
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [2:0]  reg_sel_i,
    input  wire logic [63:0] reg_wdata_i,
    output logic      [63:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    // Miss-file load and store merge decisions.
    input  wire logic        load_issue_i,
    input  wire logic [39:0] load_addr_i,
    input  wire logic        load_target_nomerge_i,
    output logic             load_merge_ok_o,
    output logic             load_alloc_nomerge_o,
    input  wire logic        store_issue_i,
    input  wire logic        store_target_nomerge_i,
    output logic             store_merge_ok_o,
    output logic             store_alloc_nomerge_o,
    // Write buffer status and flush.
    input  wire logic        wb_valid_i,
    input  wire logic        wb_second_i,
    input  wire logic        load_locked_i,
    input  wire logic        wb_grant_i,
    output logic             wb_flush_o,
    // Secondary cache arbitration.
    input  wire logic        data_read_miss_req_i,
    input  wire logic        wb_req_i,
    input  wire logic [3:0]  other_req_i,
    output logic             data_read_miss_req_o,
    output logic             wb_req_o,
    output logic      [3:0]  other_req_o,
    // Outstanding request status.
    input  wire logic        read_outstanding_i,
    input  wire logic        write_outstanding_i,
    // Cache, privilege mode and counter outputs.
    output logic             cache_invalidate_all_o,
    output logic      [1:0]  alternate_privilege_mode_o,
    output logic      [63:0] cycle_count_o,
    output logic             counter_enabled_o
);
    logic                 rst_meta_ff;
    logic                 rst_n_ff;
    logic [5:0]           mode_ff;
    logic                 flush_ff;
    mum_pkg::mum_priv_t   alt_ff;
    logic [63:0]          rdata_ff;
    logic                 rvalid_ff;
    logic [63:0]          count;
    logic                 wb_low_req;
    logic                 wr_mode;
    logic                 wr_flush;
    logic                 wr_alt;
    logic                 wr_count;
    logic                 wr_ctl;
    logic [7:0]           mode_view;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    // Reset asserts at once and releases through two flops.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    // Selects 0 to 4 each map to one register write strobe; selects 5 to 7 write nothing.
    always_comb begin
        wr_mode  = 1'b0;
        wr_flush = 1'b0;
        wr_alt   = 1'b0;
        wr_count = 1'b0;
        wr_ctl   = 1'b0;
        if (reg_sel_i == mum_pkg::SEL_MODE) begin
            wr_mode = reg_wr_i;
        end else if (reg_sel_i == mum_pkg::SEL_FLUSH) begin
            wr_flush = reg_wr_i;
        end else if (reg_sel_i == mum_pkg::SEL_ALT) begin
            wr_alt = reg_wr_i;
        end else if (reg_sel_i == mum_pkg::SEL_COUNT) begin
            wr_count = reg_wr_i;
        end else if (reg_sel_i == mum_pkg::SEL_CTL) begin
            wr_ctl = reg_wr_i;
        end
    end

    // ----------------------------------------------------------------
    // Miss-file mode control
    // ----------------------------------------------------------------
    // Only the six control bits are stored; pending bits are live status.
    always_ff @(posedge clock_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            mode_ff <= mum_pkg::MODE_RESET;
        end else begin
            if (wr_mode) begin
                mode_ff <= reg_wdata_i[mum_pkg::MODE_CTRL_W-1:0];
            end
            if (timeout_reset_i) begin
                mode_ff[mum_pkg::BIT_ARB_DIS] <= 1'b0;
            end
        end
    end

    // Pending bits mirror miss-file occupancy, never a stored value.
    assign mode_view = {write_outstanding_i, read_outstanding_i, mode_ff};

    // ----------------------------------------------------------------
    // Cache flush and alternate mode
    // ----------------------------------------------------------------
    // Any flush register write yields a one-cycle invalidate pulse.
    always_ff @(posedge clock_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            flush_ff <= 1'b0;
        end else begin
            flush_ff <= wr_flush;
        end
    end

    // Alternate mode is write-only and feeds privileged accesses.
    always_ff @(posedge clock_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            alt_ff <= mum_pkg::MUM_KERNEL;
        end else if (wr_alt) begin
            alt_ff <= mum_pkg::mum_priv_t'(reg_wdata_i[mum_pkg::ALT_LSB +: 2]);
        end
    end

    assign cache_invalidate_all_o     = flush_ff;
    assign alternate_privilege_mode_o = alt_ff;

    // ----------------------------------------------------------------
    // Merge decisions
    // ----------------------------------------------------------------
    // A load may merge only if merging is on, the target entry was not
    // built under no-merge, and it is not a blocked I/O load.
    assign load_merge_ok_o = load_issue_i && !mode_ff[mum_pkg::BIT_RD_NOMERGE]
                             && !load_target_nomerge_i
                             && !(mode_ff[mum_pkg::BIT_IO_BLOCK]
                                  && load_addr_i[mum_pkg::IO_ADDR_BIT]);
    // The new entry records that it must never merge.
    assign load_alloc_nomerge_o = load_issue_i && mode_ff[mum_pkg::BIT_RD_NOMERGE];

    // Stores follow the same policy in the write buffer, without the I/O block.
    assign store_merge_ok_o = store_issue_i && !mode_ff[mum_pkg::BIT_WR_NOMERGE]
                              && !store_target_nomerge_i;
    assign store_alloc_nomerge_o = store_issue_i && mode_ff[mum_pkg::BIT_WR_NOMERGE];

    // ----------------------------------------------------------------
    // Write buffer flush and arbitration
    // ----------------------------------------------------------------
    // Forced flush follows buffer occupancy.
    assign wb_flush_o = mode_ff[mum_pkg::BIT_WB_FLUSH] && wb_valid_i;

    mum_wb_arbiter #(
        .TIMER_CYCLES (mum_pkg::WB_TIMER_CYCLES)
    ) u_wb_arbiter (
        .clock_i         (clock_i),
        .rst_n_i         (rst_n_ff),
        .timer_disable_i (mode_ff[mum_pkg::BIT_TMR_DIS]),
        .wb_valid_i      (wb_valid_i),
        .wb_second_i     (wb_second_i),
        .load_locked_i   (load_locked_i),
        .wb_grant_i      (wb_grant_i),
        .wb_low_req_o    (wb_low_req)
    );

    // Arbitration disable gates only read and write buffer requests.
    assign data_read_miss_req_o = data_read_miss_req_i && !mode_ff[mum_pkg::BIT_ARB_DIS];
    assign wb_req_o    = (wb_req_i || wb_low_req) && !mode_ff[mum_pkg::BIT_ARB_DIS];
    assign other_req_o = other_req_i;

    // ----------------------------------------------------------------
    // Cycle counter
    // ----------------------------------------------------------------
    mum_cycle_counter #(
        .DELAY (mum_pkg::ENA_DELAY)
    ) u_cycle_counter (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_ff),
        .hi_wr_i   (wr_count),
        .ctl_wr_i  (wr_ctl),
        .wdata_i   (reg_wdata_i),
        .count_o   (count),
        .enabled_o (counter_enabled_o)
    );

    assign cycle_count_o = count;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Reads answer one cycle later; write-only registers read as zero.
    always_ff @(posedge clock_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdata_ff  <= 64'h0000_0000_0000_0000;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd_i;
            if (reg_rd_i) begin
                if (reg_sel_i == mum_pkg::SEL_MODE) begin
                    rdata_ff <= {56'h0, mode_view};
                end else if (reg_sel_i == mum_pkg::SEL_COUNT) begin
                    rdata_ff <= count;
                end else begin
                    rdata_ff <= 64'h0000_0000_0000_0000;
                end
            end
        end
    end

    assign reg_rdata_o  = rdata_ff;
    assign reg_rvalid_o = rvalid_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_timeout_clear: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        timeout_reset_i && !wr_mode |=> !mode_ff[5] && mode_ff[4:0] == $past(mode_ff[4:0]))
        else $error("timeout reset disturbed mode bits");
    a_pending_ignored: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        reg_rd_i && reg_sel_i == mum_pkg::SEL_MODE
        |=> reg_rdata_o[7:6] == $past({write_outstanding_i, read_outstanding_i}))
        else $error("pending bits not live");
    a_read_nomerge: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        mode_ff[0] && load_issue_i |-> !load_merge_ok_o && load_alloc_nomerge_o)
        else $error("load merged under read merge disable");
    a_write_nomerge: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        mode_ff[2] && store_issue_i |-> !store_merge_ok_o && store_alloc_nomerge_o)
        else $error("store merged under write merge disable");
    a_io_block: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        mode_ff[3] && load_addr_i[39] |-> !load_merge_ok_o)
        else $error("I/O load merged");
    a_force_flush: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        wb_flush_o == (mode_ff[1] && wb_valid_i))
        else $error("forced flush wrong");
    a_arb_block: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        $past(wr_mode && reg_wdata_i[5] && !timeout_reset_i) |-> !data_read_miss_req_o && !wb_req_o)
        else $error("blocked request reached arbiter");
    a_flush_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        wr_flush |=> cache_invalidate_all_o ##1 (cache_invalidate_all_o == $past(wr_flush)))
        else $error("flush write gave no invalidate pulse");
    a_count_read: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        reg_rd_i && reg_sel_i == mum_pkg::SEL_COUNT |=> reg_rvalid_o && reg_rdata_o == $past(count))
        else $error("counter read returned wrong value");
    // Stored control bits follow a write; the pending bits are never stored.
    a_mode_store: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        wr_mode && !timeout_reset_i |=> mode_ff == $past(reg_wdata_i[5:0]))
        else $error("mode write stored wrong control bits");
    a_timeout_wins: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        timeout_reset_i |=> !mode_ff[5])
        else $error("arbitration disable survived timeout reset");
    a_io_load_free: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        load_issue_i && mode_ff[3:0] == 4'h0 && !load_target_nomerge_i |-> load_merge_ok_o)
        else $error("load refused merge with merge controls off");
    // Write-only registers: flush pulses only after a write, alternate mode follows writes.
    a_flush_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        !wr_flush |=> !cache_invalidate_all_o)
        else $error("invalidate pulse without flush write");
    a_alt_load: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        wr_alt |=> alternate_privilege_mode_o == $past(reg_wdata_i[1:0]))
        else $error("alternate mode did not follow write");
    a_wo_read_zero: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
        reg_rd_i && (reg_sel_i == mum_pkg::SEL_FLUSH || reg_sel_i == mum_pkg::SEL_ALT) |=> reg_rdata_o == '0)
        else $error("write-only register read nonzero");
endmodule : mum_test_cycle_regs
`default_nettype wire

// ==== verif/mum_test_cycle_regs_tb.sv ====
// Self-checking bench for the memory unit test, mode and cycle counter registers.
// Assumes the mum_ package and design files are compiled first; the bench drives every port.
`timescale 1ns/1ps
`default_nettype none
module mum_test_cycle_regs_tb;
    logic        clock_i = 1'b0, resetn_i = 1'b0, timeout_reset_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [2:0]  reg_sel_i = 3'h0;
    logic [63:0] reg_wdata_i = 64'h0;
    logic [39:0] load_addr_i = 40'h0;
    logic [3:0]  other_req_i = 4'hF;
    logic        load_issue_i = 1'b1, load_target_nomerge_i = 1'b0, store_issue_i = 1'b1;
    logic        store_target_nomerge_i = 1'b0, wb_valid_i = 1'b0, wb_second_i = 1'b0, load_locked_i = 1'b0;
    logic        wb_grant_i = 1'b0, data_read_miss_req_i = 1'b1, wb_req_i = 1'b0;
    logic        read_outstanding_i = 1'b0, write_outstanding_i = 1'b0;
    logic [63:0] reg_rdata_o, cycle_count_o;
    logic [1:0]  alternate_privilege_mode_o;
    logic [3:0]  other_req_o;
    logic        reg_rvalid_o, load_merge_ok_o, load_alloc_nomerge_o, store_merge_ok_o, store_alloc_nomerge_o;
    logic        wb_flush_o, data_read_miss_req_o, wb_req_o, cache_invalidate_all_o, counter_enabled_o;
    int          fails = 0, compares = 0;

    mum_test_cycle_regs mum_test_cycle_regs_inst (.*);

    // Free-running 100 MHz clock.
    always #5 clock_i = ~clock_i;

    // -------------------------------------------------------------
    // Access and compare tasks, all entered just after a rising edge
    // -------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick
    task automatic wr(input logic [2:0] sel, input logic [63:0] d);
        reg_wr_i = 1'b1;
        reg_sel_i = sel;
        reg_wdata_i = d;
        tick(1);
        reg_wr_i = 1'b0;
    endtask : wr
    // The answer stands just after the taking edge, so it is checked there.
    task automatic rd(input logic [2:0] sel, input logic [63:0] exp);
        reg_rd_i = 1'b1;
        reg_sel_i = sel;
        tick(1);
        reg_rd_i = 1'b0;
        chk(reg_rvalid_o, 64'h1);
        chk(reg_rdata_o, exp);
        tick(1);
    endtask : rd
    task automatic final_report;
        $display("compares %0d, fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // Watchdog so that a stuck run still reaches the verdict.
    initial begin
        tick(3000);
        fails++;
        $display("unexpected at %0t: run limit reached", $time);
        final_report();
    end

    // Main sequence: reset, mode bits, write buffer timer, flush, alternate_privilege_mode, counter.
    initial begin
        tick(5);
        resetn_i = 1'b1;
        tick(3);
        rd(mum_pkg::SEL_MODE, 64'h0);
        rd(mum_pkg::SEL_COUNT, 64'h0);
        chk(counter_enabled_o, 64'h0);
        chk(alternate_privilege_mode_o, 64'(mum_pkg::MUM_KERNEL));
        $display("test reset done");
        read_outstanding_i = 1'b1;
        wb_req_i = 1'b1;
        wb_valid_i = 1'b1;
        wr(mum_pkg::SEL_MODE, 64'hFF);
        rd(mum_pkg::SEL_MODE, 64'h7F);
        chk(load_merge_ok_o, 64'h0);
        chk(load_alloc_nomerge_o, 64'h1);
        chk(store_merge_ok_o, 64'h0);
        chk(store_alloc_nomerge_o, 64'h1);
        chk(wb_flush_o, 64'h1);
        chk(data_read_miss_req_o, 64'h0);
        chk(wb_req_o, 64'h0);
        chk(other_req_o, 64'hF);
        timeout_reset_i = 1'b1;
        tick(1);
        timeout_reset_i = 1'b0;
        read_outstanding_i = 1'b0;
        write_outstanding_i = 1'b1;
        rd(mum_pkg::SEL_MODE, 64'h9F);
        wr(mum_pkg::SEL_MODE, 64'h08);
        load_addr_i = 40'h80_0000_0000;
        tick(1);
        chk(load_merge_ok_o, 64'h0);
        chk(wb_flush_o, 64'h0);
        chk(data_read_miss_req_o, 64'h1);
        chk(wb_req_o, 64'h1);
        load_addr_i = 40'h0;
        wb_req_i = 1'b0;
        tick(1);
        chk(load_merge_ok_o, 64'h1);
        chk(store_merge_ok_o, 64'h1);
        load_target_nomerge_i = 1'b1;
        store_target_nomerge_i = 1'b1;
        tick(1);
        chk(load_merge_ok_o, 64'h0);
        chk(store_merge_ok_o, 64'h0);
        $display("test mode done");
        wr(mum_pkg::SEL_MODE, 64'h10);
        tick(8);
        chk(wb_req_o, 64'h0);
        load_locked_i = 1'b1;
        tick(1);
        load_locked_i = 1'b0;
        chk(wb_req_o, 64'h1);
        wb_grant_i = 1'b1;
        tick(1);
        wb_grant_i = 1'b0;
        wb_second_i = 1'b1;
        tick(1);
        wb_second_i = 1'b0;
        chk(wb_req_o, 64'h1);
        wb_grant_i = 1'b1;
        tick(1);
        wb_grant_i = 1'b0;
        wr(mum_pkg::SEL_MODE, 64'h0);
        tick(50);
        chk(wb_req_o, 64'h0);
        tick(20);
        chk(wb_req_o, 64'h1);
        $display("test timer done");
        wr(mum_pkg::SEL_FLUSH, 64'h0);
        chk(cache_invalidate_all_o, 64'h1);
        tick(1);
        chk(cache_invalidate_all_o, 64'h0);
        for (int m = 0; m < 4; m++) begin
            wr(mum_pkg::SEL_ALT, 64'(m));
            chk(alternate_privilege_mode_o, 64'(m));
            tick(1);
        end
        $display("test flush and mode done");
        wr(mum_pkg::SEL_COUNT, 64'h12345678_FFFFFFFF);
        chk(cycle_count_o, 64'h12345678_00000000);
        tick(1);
        wr(mum_pkg::SEL_CTL, 64'h1_0000ABCD);
        chk(cycle_count_o, 64'h12345678_0000ABC0);
        tick(1);
        chk(counter_enabled_o, 64'h0);
        tick(1);
        chk(counter_enabled_o, 64'h1);
        chk(cycle_count_o, 64'h12345678_0000ABC0);
        tick(1);
        chk(cycle_count_o, 64'h12345678_0000ABC1);
        rd(mum_pkg::SEL_COUNT, 64'h12345678_0000ABC1);
        chk(cycle_count_o, 64'h12345678_0000ABC3);
        $display("test counter done");
        // A mid-run chip reset clears the stored mode control bits and stops the counter; the write pending bit still reads 1.
        wr(mum_pkg::SEL_MODE, 64'h3F);
        resetn_i = 1'b0;
        tick(2);
        resetn_i = 1'b1;
        tick(3);
        rd(mum_pkg::SEL_MODE, 64'h80);
        rd(mum_pkg::SEL_COUNT, 64'h0);
        chk(counter_enabled_o, 64'h0);
        $display("test reset again done");
        final_report();
    end
endmodule : mum_test_cycle_regs_tb
`default_nettype wire
